// ### verilog/pmlc_pkg.sv
// constants for the bus hold limit, bus hint and memory window configuration block
package pmlc_pkg;
    // configuration byte offsets and dword index width
    localparam logic [7:0] OFS_BUS_HOLD_LIMIT          = 8'h0d;
    localparam logic [7:0] OFS_BURST_PERIOD_REQUEST    = 8'h3e;
    localparam logic [7:0] OFS_ACCESS_INTERVAL_REQUEST = 8'h3f;
    localparam logic [7:0] OFS_MEMORY_WINDOW_BASE      = 8'h14;
    localparam int         CFG_DWORD_W                 = 6;

    // reset values
    localparam logic [7:0]  RST_BUS_HOLD_LIMIT          = 8'h00;
    localparam logic [7:0]  RST_BURST_PERIOD_REQUEST    = 8'h50;
    localparam logic [7:0]  RST_ACCESS_INTERVAL_REQUEST = 8'h0a;
    localparam logic [31:0] RST_MEMORY_WINDOW_BASE      = 32'h00000000;

    // field positions inside the registers
    localparam int HOLD_LSB        = 3;
    localparam int HOLD_MSB        = 7;
    localparam int HOLD_W          = HOLD_MSB - HOLD_LSB + 1;
    localparam int ACCESS_LOAD_LSB = 1;
    localparam int ACCESS_LOAD_MSB = 5;
    localparam int BURST_LOAD_LSB  = 4;
    localparam int BURST_LOAD_MSB  = 7;
    localparam int MEM_VALID_BIT   = 0;
    localparam int MAP_LO_BIT      = 1;
    localparam int MAP_HI_BIT      = 2;
    localparam int MEM_BASE_LSB    = 8;
    localparam int MEM_BASE_W      = 32 - MEM_BASE_LSB;

    // setup word layout and eeprom word addresses
    localparam int             EE_ADDR_W           = 6;
    localparam int             EE_DATA_W           = 16;
    localparam int             SETUP_ACCESS_LSB    = 0;
    localparam int             SETUP_BURST_LSB     = 5;
    localparam int             SETUP_MEM_DIS_BIT   = 9;
    localparam int             SETUP_LOW_MEG_BIT   = 10;
    localparam logic [5:0]     EE_ADDR_SETUP       = 6'h00;
    localparam logic [5:0]     EE_ADDR_BASE_HI     = 6'h04;
    localparam logic [5:0]     EE_ADDR_BASE_LO     = 6'h05;

    // timing
    localparam int HOLD_UNIT_CLKS = 8;
    localparam int HOLD_COUNT_W   = 8;
    localparam int HINT_UNIT_NS   = 250;
endpackage

// ### verilog/pmlc_if.sv
// signals between the top and its latency timer and setup loader
`timescale 1ns/1ps
`default_nettype none
interface pmlc_if;
    logic [pmlc_pkg::HOLD_W-1:0]    hold_limit;
    logic                           frame_start;
    logic                           tenure_end;
    logic                           gnt_n;
    logic                           expired;
    logic                           release_bus;
    logic                           ee_valid;
    logic [pmlc_pkg::EE_ADDR_W-1:0] ee_addr;
    logic [pmlc_pkg::EE_DATA_W-1:0] ee_data;
    logic                           forced;
    logic                           setup_stb;
    logic [pmlc_pkg::EE_DATA_W-1:0] setup_word;
    logic                           base_stb;
    logic [31:0]                    base_word;

    modport timer (input hold_limit, frame_start, tenure_end, gnt_n,
                   output expired, release_bus);
    modport timer_user (output hold_limit, frame_start, tenure_end, gnt_n,
                        input expired, release_bus);
    modport loader (input ee_valid, ee_addr, ee_data, forced,
                    output setup_stb, setup_word, base_stb, base_word);
    modport loader_user (output ee_valid, ee_addr, ee_data, forced,
                         input setup_stb, setup_word, base_stb, base_word);
endinterface
`default_nettype wire

// ### verilog/pmlc_lat_timer.sv
// bus tenure latency counter
`timescale 1ns/1ps
`default_nettype none
module pmlc_lat_timer
(
    input  wire logic CLK_I,
    input  wire logic RESETN_I,
    pmlc_if.timer     tif
);
    typedef struct packed {
        logic [pmlc_pkg::HOLD_COUNT_W-1:0] count;
        logic                              running;
        logic                              expired;
    } pmlc_tmr_s;

    pmlc_tmr_s st_reg;
    pmlc_tmr_s st_next;

    always_comb
    begin
        st_next = st_reg;
        if (tif.frame_start)
        begin
            // a zero limit expires at once, so the grant alone governs release
            st_next.count   = {tif.hold_limit, 3'h0};
            st_next.running = 1'b1;
            st_next.expired = (tif.hold_limit == '0);
        end
        else if (tif.tenure_end)
        begin
            st_next.running = 1'b0;
            st_next.expired = 1'b0;
        end
        else if (st_reg.running && !st_reg.expired)
        begin
            st_next.count   = st_reg.count - 8'h01;
            st_next.expired = (st_reg.count == 8'h01);
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tif.expired     = st_reg.expired;
    // stays on the bus while grant is held even after expiry
    assign tif.release_bus = st_reg.running && st_reg.expired && tif.gnt_n;
endmodule
`default_nettype wire

// ### verilog/pmlc_setup_load.sv
// collects the eeprom setup word and the forced-mode memory base words
`timescale 1ns/1ps
`default_nettype none
module pmlc_setup_load
(
    input  wire logic CLK_I,
    input  wire logic RESETN_I,
    pmlc_if.loader    lif
);
    typedef struct packed {
        logic [pmlc_pkg::EE_DATA_W-1:0] base_hi;
        logic                           hi_seen;
        logic                           setup_stb;
        logic [pmlc_pkg::EE_DATA_W-1:0] setup_word;
        logic                           base_stb;
        logic [31:0]                    base_word;
    } pmlc_ld_s;

    pmlc_ld_s st_reg;
    pmlc_ld_s st_next;

    always_comb
    begin
        st_next           = st_reg;
        st_next.setup_stb = 1'b0;
        st_next.base_stb  = 1'b0;
        if (lif.ee_valid && lif.ee_addr == pmlc_pkg::EE_ADDR_SETUP)
        begin
            st_next.setup_word = lif.ee_data;
            st_next.setup_stb  = 1'b1;
        end
        if (lif.ee_valid && lif.forced && lif.ee_addr == pmlc_pkg::EE_ADDR_BASE_HI)
        begin
            st_next.base_hi = lif.ee_data;
            st_next.hi_seen = 1'b1;
        end
        // a low word without its upper word is dropped, never half-applied
        if (lif.ee_valid && lif.forced && lif.ee_addr == pmlc_pkg::EE_ADDR_BASE_LO
            && st_reg.hi_seen)
        begin
            st_next.base_word = {st_reg.base_hi, lif.ee_data};
            st_next.base_stb  = 1'b1;
            st_next.hi_seen   = 1'b0;
        end
        if (!lif.forced)
            st_next.hi_seen = 1'b0;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign lif.setup_stb  = st_reg.setup_stb;
    assign lif.setup_word = st_reg.setup_word;
    assign lif.base_stb   = st_reg.base_stb;
    assign lif.base_word  = st_reg.base_word;
endmodule
`default_nettype wire

// ### verilog/pmlc_top.sv
// configuration registers for bus hold limit, bus hints and the memory window
`timescale 1ns/1ps
`default_nettype none
// How it works
// - hold limit bits 7:3, eight-clock units, writable
// - hold limit bits 2:0 reserved, read zero
// - latency counter starts at each frame start
// - after expiry release once grant drops
// - access interval request reports bus frequency need
// - setup word loads access interval bits 5:1
// - burst period request reports burst length need
// - setup word loads burst period bits 7:4
// - setup word can disable memory window
// - forced mode loads base from words 04/05
// - bit 0 marks memory base valid, writable
// - placement bit2 zero, bit1 from low-megabyte select
// - placement 00 anywhere, 01 below 1MB
// - base bits 7:3 reserved, read zero
// - base bits 31:8 give 256-byte window
module pmlc_top
#(
    parameter logic [7:0] MEM_BASE_OFFSET = pmlc_pkg::OFS_MEMORY_WINDOW_BASE
)
(
    input  wire logic                           CLK_I,
    input  wire logic                           RESETN_I,
    input  wire logic                           CFG_SEL_I,
    input  wire logic                           CFG_WE_I,
    input  wire logic [pmlc_pkg::CFG_DWORD_W-1:0] CFG_DWORD_I,
    input  wire logic [3:0]                     CFG_BE_I,
    input  wire logic [31:0]                    CFG_WDATA_I,
    output logic      [31:0]                    CFG_RDATA_O,
    output logic                                CFG_ACK_O,
    input  wire logic                           FRAME_START_I,
    input  wire logic                           TENURE_END_I,
    input  wire logic                           GNT_N_I,
    output logic                                LAT_EXPIRED_O,
    output logic                                BUS_RELEASE_O,
    input  wire logic                           EE_VALID_I,
    input  wire logic [pmlc_pkg::EE_ADDR_W-1:0] EE_ADDR_I,
    input  wire logic [pmlc_pkg::EE_DATA_W-1:0] EE_DATA_I,
    input  wire logic                           FORCED_SETUP_I,
    input  wire logic [31:0]                    MEM_ADDR_I,
    output logic                                MEM_HIT_O,
    output logic      [31:0]                    MEM_BASE_O,
    output logic                                MEM_DECODE_EN_O
);
    // the window must sit in the base address area and stay off the i/o base slot
    if (MEM_BASE_OFFSET[1:0] != 2'h0 || MEM_BASE_OFFSET < 8'h14 || MEM_BASE_OFFSET > 8'h24)
    begin : g_bad_offset
        $error("memory window base offset must be an aligned base address slot");
    end

    localparam logic [5:0] DW_HOLD = pmlc_pkg::OFS_BUS_HOLD_LIMIT[7:2];
    localparam logic [5:0] DW_HINT = pmlc_pkg::OFS_BURST_PERIOD_REQUEST[7:2];
    localparam logic [5:0] DW_MEM  = MEM_BASE_OFFSET[7:2];
    localparam int         LN_HOLD = int'(pmlc_pkg::OFS_BUS_HOLD_LIMIT[1:0]);
    localparam int         LN_BRST = int'(pmlc_pkg::OFS_BURST_PERIOD_REQUEST[1:0]);
    localparam int         LN_ACC  = int'(pmlc_pkg::OFS_ACCESS_INTERVAL_REQUEST[1:0]);
    localparam int         ACC_LDW = pmlc_pkg::ACCESS_LOAD_MSB - pmlc_pkg::ACCESS_LOAD_LSB + 1;
    localparam int         BRS_LDW = pmlc_pkg::BURST_LOAD_MSB - pmlc_pkg::BURST_LOAD_LSB + 1;

    // both hint bytes are served from one read dword
    if (pmlc_pkg::OFS_ACCESS_INTERVAL_REQUEST[7:2] != DW_HINT)
    begin : g_bad_hint
        $error("burst and access hint bytes must share one dword");
    end

    // dword constants are six bits wide, matching the index port
    if (pmlc_pkg::CFG_DWORD_W != 6)
    begin : g_bad_dword
        $error("config dword index must be six bits");
    end

    // the timer loads the limit shifted by three places
    if (pmlc_pkg::HOLD_UNIT_CLKS != 2 ** 3)
    begin : g_bad_unit
        $error("hold limit unit must be eight clocks");
    end

    // the counter must hold the largest limit times eight
    if (pmlc_pkg::HOLD_COUNT_W < pmlc_pkg::HOLD_W + 3)
    begin : g_bad_count
        $error("latency counter narrower than the largest hold limit");
    end

    // the read byte is rebuilt as the limit above three zero bits
    if (pmlc_pkg::HOLD_MSB != 7 || pmlc_pkg::HOLD_LSB != 3)
    begin : g_bad_hold
        $error("hold limit field must fill bits 7 to 3");
    end

    // setup word fields must not overlap and must fit one eeprom word
    if (pmlc_pkg::SETUP_ACCESS_LSB + ACC_LDW > pmlc_pkg::SETUP_BURST_LSB
        || pmlc_pkg::SETUP_BURST_LSB + BRS_LDW > pmlc_pkg::SETUP_MEM_DIS_BIT
        || pmlc_pkg::SETUP_LOW_MEG_BIT >= pmlc_pkg::EE_DATA_W)
    begin : g_bad_setup
        $error("setup word fields overlap or leave the eeprom word");
    end

    // the window base must sit above the placement and valid bits
    if (pmlc_pkg::MEM_BASE_LSB <= pmlc_pkg::MAP_HI_BIT)
    begin : g_bad_base
        $error("window base field overlaps its control bits");
    end

    // eeprom word addresses are six-bit constants
    if (pmlc_pkg::EE_ADDR_W != 6)
    begin : g_bad_ee
        $error("eeprom word address must be six bits");
    end

    // host view by dword and byte lane:
    //   hold dword lane 1: bus hold limit
    //   hint dword lane 2: burst period request, lane 3: access interval request
    //   window dword: base in lanes 1 to 3, valid bit in lane 0

    typedef struct packed {
        logic                            gnt_n_meta;
        logic                            gnt_n_sync;
        logic [pmlc_pkg::HOLD_W-1:0]     hold_limit;
        logic [7:0]                      burst_period_request;
        logic [7:0]                      access_interval_request;
        logic [pmlc_pkg::MEM_BASE_W-1:0] mem_base;
        logic                            memory_window_valid;
        logic                            low_megabyte_select;
        logic                            mem_disabled;
        logic [31:0]                     rdata;
        logic                            ack;
    } pmlc_top_s;

    pmlc_top_s st_reg;
    pmlc_top_s st_next;

    pmlc_if u_if ();

    logic [7:0]  bus_hold_limit_byte;
    logic [31:0] memory_window_base_word;
    logic [1:0]  memory_placement_type;

    // reserved low bits never hold state, so they always read zero
    assign bus_hold_limit_byte = {st_reg.hold_limit, 3'h0};

    // bit 2 tied low; 1x is never produced
    assign memory_placement_type = {1'b0, st_reg.low_megabyte_select};

    always_comb
    begin
        memory_window_base_word = '0;
        if (!st_reg.mem_disabled)
        begin
            memory_window_base_word[31:pmlc_pkg::MEM_BASE_LSB] = st_reg.mem_base;
            memory_window_base_word[pmlc_pkg::MAP_HI_BIT:pmlc_pkg::MAP_LO_BIT] =
                memory_placement_type;
            memory_window_base_word[pmlc_pkg::MEM_VALID_BIT] = st_reg.memory_window_valid;
        end
    end

    always_comb
    begin
        st_next            = st_reg;
        st_next.gnt_n_meta = GNT_N_I;
        st_next.gnt_n_sync = st_reg.gnt_n_meta;
        st_next.ack        = CFG_SEL_I;
        st_next.rdata      = '0;

        // host configuration writes, byte lane by byte lane
        if (CFG_SEL_I && CFG_WE_I)
        begin
            if (CFG_DWORD_I == DW_HOLD && CFG_BE_I[LN_HOLD])
            begin
                st_next.hold_limit =
                    CFG_WDATA_I[LN_HOLD*8+pmlc_pkg::HOLD_MSB -: pmlc_pkg::HOLD_W];
            end

            // lane 0 keeps only the valid bit; reserved and placement bits are not stored
            if (CFG_DWORD_I == DW_MEM && !st_reg.mem_disabled)
            begin
                if (CFG_BE_I[0])
                begin
                    st_next.memory_window_valid = CFG_WDATA_I[pmlc_pkg::MEM_VALID_BIT];
                end
                if (CFG_BE_I[1])
                begin
                    st_next.mem_base[7:0] = CFG_WDATA_I[15:8];
                end
                if (CFG_BE_I[2])
                begin
                    st_next.mem_base[15:8] = CFG_WDATA_I[23:16];
                end
                if (CFG_BE_I[3])
                begin
                    st_next.mem_base[23:16] = CFG_WDATA_I[31:24];
                end
            end
        end

        // host configuration reads; unmapped dwords read zero
        if (CFG_SEL_I && !CFG_WE_I)
        begin
            case (CFG_DWORD_I)
                DW_HOLD:
                begin
                    st_next.rdata[LN_HOLD*8 +: 8] = bus_hold_limit_byte;
                end
                DW_HINT:
                begin
                    st_next.rdata[LN_BRST*8 +: 8] = st_reg.burst_period_request;
                    st_next.rdata[LN_ACC*8 +: 8]  = st_reg.access_interval_request;
                end
                DW_MEM:
                begin
                    st_next.rdata = memory_window_base_word;
                end
                default:
                begin
                    st_next.rdata = '0;
                end
            endcase
        end

        // eeprom loads come after host writes so a load in the same cycle wins
        if (u_if.setup_stb)
        begin
            st_next.access_interval_request[pmlc_pkg::ACCESS_LOAD_MSB:pmlc_pkg::ACCESS_LOAD_LSB] =
                u_if.setup_word[pmlc_pkg::SETUP_ACCESS_LSB +: ACC_LDW];
            st_next.burst_period_request[pmlc_pkg::BURST_LOAD_MSB:pmlc_pkg::BURST_LOAD_LSB] =
                u_if.setup_word[pmlc_pkg::SETUP_BURST_LSB +: BRS_LDW];
            st_next.mem_disabled        = u_if.setup_word[pmlc_pkg::SETUP_MEM_DIS_BIT];
            st_next.low_megabyte_select = u_if.setup_word[pmlc_pkg::SETUP_LOW_MEG_BIT];
        end
        if (u_if.base_stb)
        begin
            st_next.mem_base            = u_if.base_word[31:pmlc_pkg::MEM_BASE_LSB];
            st_next.memory_window_valid = u_if.base_word[pmlc_pkg::MEM_VALID_BIT];
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            st_reg                         <= '0;
            st_reg.gnt_n_meta              <= 1'b1;
            st_reg.gnt_n_sync              <= 1'b1;
            st_reg.hold_limit              <=
                pmlc_pkg::RST_BUS_HOLD_LIMIT[pmlc_pkg::HOLD_MSB:pmlc_pkg::HOLD_LSB];
            st_reg.burst_period_request    <= pmlc_pkg::RST_BURST_PERIOD_REQUEST;
            st_reg.access_interval_request <= pmlc_pkg::RST_ACCESS_INTERVAL_REQUEST;
            st_reg.mem_base                <=
                pmlc_pkg::RST_MEMORY_WINDOW_BASE[31:pmlc_pkg::MEM_BASE_LSB];
            st_reg.memory_window_valid     <=
                pmlc_pkg::RST_MEMORY_WINDOW_BASE[pmlc_pkg::MEM_VALID_BIT];
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // timer sees only the second synchroniser stage
    assign u_if.hold_limit  = st_reg.hold_limit;
    assign u_if.frame_start = FRAME_START_I;
    assign u_if.tenure_end  = TENURE_END_I;
    assign u_if.gnt_n       = st_reg.gnt_n_sync;

    assign u_if.ee_valid = EE_VALID_I;
    assign u_if.ee_addr  = EE_ADDR_I;
    assign u_if.ee_data  = EE_DATA_I;
    assign u_if.forced   = FORCED_SETUP_I;

    pmlc_lat_timer u_timer
    (
        .CLK_I    (CLK_I),
        .RESETN_I (RESETN_I),
        .tif      (u_if.timer)
    );

    pmlc_setup_load u_loader
    (
        .CLK_I    (CLK_I),
        .RESETN_I (RESETN_I),
        .lif      (u_if.loader)
    );

    // host answers come straight from the state register
    assign CFG_RDATA_O     = st_reg.rdata;
    assign CFG_ACK_O       = st_reg.ack;

    // timer status passes out unchanged
    assign LAT_EXPIRED_O   = u_if.expired;
    assign BUS_RELEASE_O   = u_if.release_bus;
    assign MEM_BASE_O      = memory_window_base_word;
    assign MEM_DECODE_EN_O = !st_reg.mem_disabled && st_reg.memory_window_valid;
    // decoding the upper 24 bits claims exactly 256 bytes
    assign MEM_HIT_O       = MEM_DECODE_EN_O &&
                             MEM_ADDR_I[31:pmlc_pkg::MEM_BASE_LSB] == st_reg.mem_base;
endmodule
`default_nettype wire

// ### sim/pmlc_sva.sv
// port-level assertions for the configuration block
`timescale 1ns/1ps
`default_nettype none
module pmlc_sva
(
    input wire logic        CLK_I,
    input wire logic        RESETN_I,
    input wire logic        CFG_SEL_I,
    input wire logic [5:0]  CFG_DWORD_I,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic        CFG_ACK_O,
    input wire logic        FRAME_START_I,
    input wire logic        TENURE_END_I,
    input wire logic        GNT_N_I,
    input wire logic        LAT_EXPIRED_O,
    input wire logic        BUS_RELEASE_O,
    input wire logic [31:0] MEM_ADDR_I,
    input wire logic        MEM_HIT_O,
    input wire logic [31:0] MEM_BASE_O,
    input wire logic        MEM_DECODE_EN_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    AST_ACK_NEXT: assert property (CFG_SEL_I |=> CFG_ACK_O)
        else $error("no acknowledge after access");
    AST_HOLD_RSV: assert property (CFG_ACK_O && $past(CFG_DWORD_I) == 6'h03
        |-> CFG_RDATA_O[10:8] == 3'h0)
        else $error("hold limit low bits not zero");
    AST_BASE_RSV: assert property (MEM_BASE_O[7:2] == 6'h00)
        else $error("window base low field not zero");
    AST_HIT: assert property (MEM_HIT_O == (MEM_DECODE_EN_O
        && MEM_ADDR_I[31:8] == MEM_BASE_O[31:8]))
        else $error("window hit mismatch");
    AST_DEC_VALID: assert property (MEM_DECODE_EN_O |-> MEM_BASE_O[0])
        else $error("decode without valid bit");
    // grant passes two sync flops before it may release the bus
    AST_REL: assert property (BUS_RELEASE_O |-> LAT_EXPIRED_O && $past(GNT_N_I, 2))
        else $error("release without expiry and dropped grant");
    AST_EXP_HOLD: assert property (LAT_EXPIRED_O && !TENURE_END_I && !FRAME_START_I
        |=> LAT_EXPIRED_O)
        else $error("expiry lost inside tenure");
    AST_TEND: assert property (TENURE_END_I && !FRAME_START_I |=> !LAT_EXPIRED_O)
        else $error("expiry kept after tenure end");

    COV_EXP: cover property ($rose(LAT_EXPIRED_O));
    COV_REL: cover property ($rose(BUS_RELEASE_O));
    COV_HIT: cover property (MEM_HIT_O);
endmodule
bind pmlc_top pmlc_sva i_pmlc_sva (.CLK_I, .RESETN_I, .CFG_SEL_I, .CFG_DWORD_I,
    .CFG_RDATA_O, .CFG_ACK_O, .FRAME_START_I, .TENURE_END_I, .GNT_N_I, .LAT_EXPIRED_O,
    .BUS_RELEASE_O, .MEM_ADDR_I, .MEM_HIT_O, .MEM_BASE_O, .MEM_DECODE_EN_O);
`default_nettype wire

// ### sim/pmlc_arb_model.sv
// bus arbiter model: withdraws grant on command and ends the tenure on release
`timescale 1ns/1ps
`default_nettype none
module pmlc_arb_model
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic drop_i,
    input  wire logic release_i,
    output logic      gnt_n_o,
    output logic      tenure_end_o
);
    // tenure end never stays high two cycles running; a release held longer than that pulses it every other cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gnt_n_o      <= 1'b0;
            tenure_end_o <= 1'b0;
        end
        else
        begin
            gnt_n_o      <= drop_i;
            tenure_end_o <= release_i && !tenure_end_o;
        end
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [5:0] BD = pmlc_pkg::OFS_MEMORY_WINDOW_BASE[7:2];
    logic        clk, resetn, sel, we, frame, drop, ee_v, forced, tend, gnt_n;
    logic        ack, exp_o, rel, hit, dec;
    logic [5:0]  dword, ee_a;
    logic [3:0]  be;
    logic [15:0] ee_d;
    logic [31:0] wd, rdata, base, maddr, got;
    int          errors, checked, n;

    pmlc_top i_pmlc_top (.CLK_I(clk), .RESETN_I(resetn), .CFG_SEL_I(sel), .CFG_WE_I(we),
        .CFG_DWORD_I(dword), .CFG_BE_I(be), .CFG_WDATA_I(wd), .CFG_RDATA_O(rdata),
        .CFG_ACK_O(ack), .FRAME_START_I(frame), .TENURE_END_I(tend), .GNT_N_I(gnt_n),
        .LAT_EXPIRED_O(exp_o), .BUS_RELEASE_O(rel), .EE_VALID_I(ee_v), .EE_ADDR_I(ee_a),
        .EE_DATA_I(ee_d), .FORCED_SETUP_I(forced), .MEM_ADDR_I(maddr), .MEM_HIT_O(hit),
        .MEM_BASE_O(base), .MEM_DECODE_EN_O(dec));
    pmlc_arb_model i_pmlc_arb_model (.clk_i(clk), .rst_n_i(resetn), .drop_i(drop),
        .release_i(rel), .gnt_n_o(gnt_n), .tenure_end_o(tend));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // ack and read data stand for one cycle, so both are taken at the next falling edge
    task automatic acc(input logic w, input logic [5:0] d, input logic [3:0] b,
                       input logic [31:0] v);
        @(negedge clk);
        sel = 1'b1;
        we = w;
        dword = d;
        be = b;
        wd = v;
        @(negedge clk);
        sel = 1'b0;
        got = rdata;
        chk({31'h0, ack}, 32'h1);
    endtask

    task automatic rdc(input logic [5:0] d, input logic [31:0] e);
        acc(1'b0, d, 4'h0, 32'h0);
        chk(got, e);
    endtask

    task automatic ee(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        ee_v = 1'b1;
        ee_a = a;
        ee_d = d;
        @(negedge clk);
        ee_v = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic lat(input logic [4:0] l);
        acc(1'b1, 6'h03, 4'h2, {16'h0, l, 11'h0});
        @(negedge clk);
        frame = 1'b1;
        @(negedge clk);
        frame = 1'b0;
        n = 0;
        while (exp_o !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk(n, 8 * l);
        repeat (4) @(negedge clk);
        chk({31'h0, rel}, 32'h0);
        drop = 1'b1;
        n = 0;
        while (rel !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, rel}, 32'h1);
        repeat (3) @(negedge clk);
        chk({31'h0, exp_o}, 32'h0);
        drop = 1'b0;
        $display("test latency %0d done", l);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #80000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        {resetn, sel, we, frame, drop, ee_v, forced} = '0;
        {dword, ee_a, be, ee_d, wd, maddr} = '0;
        errors = 0;
        checked = 0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        rdc(6'h03, {16'h0, pmlc_pkg::RST_BUS_HOLD_LIMIT, 8'h0});
        rdc(6'h0f, {pmlc_pkg::RST_ACCESS_INTERVAL_REQUEST, pmlc_pkg::RST_BURST_PERIOD_REQUEST,
                    16'h0});
        rdc(BD, 32'h0);
        rdc(6'h20, 32'h0);
        acc(1'b1, 6'h03, 4'h2, 32'h0000f800);
        rdc(6'h03, 32'h0000f800);
        acc(1'b1, 6'h0f, 4'hc, 32'hffff0000);
        rdc(6'h0f, 32'h0a500000);
        $display("test registers done");
        ee(6'h00, 16'h04d5);
        rdc(6'h0f, 32'h2a600000);
        rdc(BD, 32'h00000002);
        acc(1'b1, BD, 4'hf, 32'habcd1203);
        rdc(BD, 32'habcd1203);
        chk(base, 32'habcd1203);
        maddr = 32'habcd12ff;
        @(negedge clk);
        chk({30'h0, hit, dec}, 32'h3);
        maddr = 32'habcd13ff;
        @(negedge clk);
        chk({31'h0, hit}, 32'h0);
        acc(1'b1, BD, 4'h1, 32'h000000f8);
        rdc(BD, 32'habcd1202);
        chk({31'h0, dec}, 32'h0);
        $display("test window done");
        ee(6'h00, 16'h0200);
        rdc(BD, 32'h0);
        chk({31'h0, dec}, 32'h0);
        ee(6'h00, 16'h0000);
        acc(1'b1, BD, 4'hf, 32'h55667701);
        rdc(BD, 32'h55667701);
        forced = 1'b1;
        ee(6'h04, 16'h1234);
        ee(6'h05, 16'h5601);
        rdc(BD, 32'h12345601);
        ee(6'h05, 16'h7701);
        rdc(BD, 32'h12345601);
        forced = 1'b0;
        $display("test setup load done");
        lat(5'd0);
        lat(5'd1);
        lat(5'd3);
        lat(5'd31);
        tally_and_finish();
    end
endmodule
`default_nettype wire
